// ===== hdl/abt_slave.sv
// Backplane data-transfer slave: 64-word memory window plus interrupt vector intake.
// Assumes open-collector pins resolved outside; every bus level pin here is active low, the output enables active high.
`default_nettype none
module abt_slave
  import abt_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  // Bus pins in
  input  wire logic              busOccupiedIn_n,
  input  wire logic [ADDR_W-1:0] addrIn_n,
  input  wire logic [1:0]        cycleCtlIn_n,
  input  wire logic [DATA_W-1:0] dataIn_n,
  input  wire logic              masterSyncIn_n,
  input  wire logic              vectorStrobeIn_n,
  // Bus pins out
  output logic [DATA_W-1:0]      dataOut_n,
  output logic [DATA_W-1:0]      dataOe,
  output logic                   slaveSyncOut_n,
  output logic                   slaveSyncOe,
  output logic                   parityFlagAOut_n,
  output logic                   parityFlagAOe,
  output logic                   parityErrorOut_n,
  output logic                   parityErrorOe,
  // User side
  input  wire logic              parityCheckOff,
  input  wire logic              corruptWrite,
  output logic                   busOccupied,
  output logic [DATA_W-1:0]      vectorWord,
  output logic                   vectorValid
);
  localparam int IN_W = 1 + ADDR_W + 2 + DATA_W + 2;

  logic [IN_W-1:0]   syncIn;
  logic              busyS, msynS, vecS;
  logic [ADDR_W-1:0] addrS;
  logic [1:0]        cycS;
  logic [DATA_W-1:0] dataS;

  // All input pins pass the agreement synchroniser; logical level is the inverse
  abt_pin_sync #(.W(IN_W)) uSync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .pinIn   ({busOccupiedIn_n, addrIn_n, cycleCtlIn_n, dataIn_n,
                masterSyncIn_n, vectorStrobeIn_n}),
    .initVal ({IN_W{1'b1}}),
    .pinOut  (syncIn)
  );
  assign {busyS, addrS, cycS, dataS, msynS, vecS} = ~syncIn;

  // Word parity, odd count of ones gives one
  function automatic logic par16(input logic [DATA_W-1:0] w);
    par16 = ^w;
  endfunction

  // Window hit on address bits 17 down to 7; the word index and bit zero play no part
  function automatic logic hitWin(input logic [ADDR_W-1:0] a);
    hitWin = (a[ADDR_W-1:WIN_LSB] == BASE_ADDR[ADDR_W-1:WIN_LSB]);
  endfunction

  logic [DATA_W-1:0] mem   [MEM_WORDS];
  logic              memPar[MEM_WORDS];

  abt_state_e        state_r, state_nxt;
  logic [DATA_W-1:0] dataOe_r, dataOe_nxt, dataVal_r, dataVal_nxt;
  logic              slave_sync_r, slave_sync_nxt, perr_r, perr_nxt, pa_r, pa_nxt;
  logic [DATA_W-1:0] vecWord_r, vecWord_nxt;
  logic              vecValid_r, vecValid_nxt, busy_r, busy_nxt;
  logic              wrEn, wrHi, wrLo, wrPar;
  logic [IDX_W-1:0]  idx;
  logic [DATA_W-1:0] wrData;
  logic              isWrite, isByte;

  assign idx     = addrS[IDX_LSB +: IDX_W];
  assign isWrite = cycS[1];
  assign isByte  = (cycS == CYC_WRITE_BYTE);

  // Slave sequencer; vector strobe wins and ignores address/control
  always_comb begin
    state_nxt    = state_r;
    dataOe_nxt   = dataOe_r;
    dataVal_nxt  = dataVal_r;
    slave_sync_nxt     = slave_sync_r;
    perr_nxt     = perr_r;
    pa_nxt       = pa_r;
    vecWord_nxt  = vecWord_r;
    vecValid_nxt = 1'b0;
    busy_nxt     = busyS;
    wrEn         = 1'b0;
    wrHi         = 1'b0;
    wrLo         = 1'b0;
    wrData       = dataS;
    wrPar        = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (vecS) begin
          vecWord_nxt  = dataS;
          vecValid_nxt = 1'b1;
          slave_sync_nxt     = 1'b1;
          state_nxt    = ST_HOLD;
        end else if (msynS && hitWin(addrS)) begin
          if (isWrite) begin
            // Master-sync doubles as data strobe: take data now
            wrEn = 1'b1;
            if (isByte) begin
              wrHi = addrS[0];
              wrLo = ~addrS[0];
            end else begin
              wrHi = 1'b1;
              wrLo = 1'b1;
            end
            slave_sync_nxt  = 1'b1;
            state_nxt = ST_HOLD;
          end else begin
            // Reads: present data and parity a cycle before slave-sync
            dataVal_nxt = mem[idx];
            dataOe_nxt  = mem[idx];
            pa_nxt      = parityCheckOff;
            perr_nxt    = ~parityCheckOff & (par16(mem[idx]) != memPar[idx]);
            state_nxt   = ST_LOAD;
          end
        end
      end
      ST_LOAD: begin
        slave_sync_nxt  = 1'b1;
        state_nxt = ST_ACK;
      end
      ST_ACK: begin
        state_nxt = ST_HOLD;
      end
      ST_HOLD: begin
        // Hold slave-sync until the master or vector strobe lets go
        if (!msynS && !vecS) begin
          slave_sync_nxt   = 1'b0;
          dataOe_nxt = '0;
          perr_nxt   = 1'b0;
          pa_nxt     = 1'b0;
          state_nxt  = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (wrEn) begin
      wrPar = par16(dataS) ^ corruptWrite;
    end
  end

  // Sequencer registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r    <= ST_IDLE;
      dataOe_r   <= '0;
      dataVal_r  <= '0;
      slave_sync_r     <= 1'b0;
      perr_r     <= 1'b0;
      pa_r       <= 1'b0;
      vecWord_r  <= '0;
      vecValid_r <= 1'b0;
      busy_r     <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      dataOe_r   <= dataOe_nxt;
      dataVal_r  <= dataVal_nxt;
      slave_sync_r     <= slave_sync_nxt;
      perr_r     <= perr_nxt;
      pa_r       <= pa_nxt;
      vecWord_r  <= vecWord_nxt;
      vecValid_r <= vecValid_nxt;
      busy_r     <= busy_nxt;
    end
  end

  // Memory has no reset; parity is merged per lane on byte writes
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      if (wrHi) begin
        mem[idx][15:8] <= wrData[15:8];
      end
      if (wrLo) begin
        mem[idx][7:0] <= wrData[7:0];
      end
      memPar[idx] <= (wrHi && wrLo) ? wrPar
                   : par16({wrHi ? wrData[15:8] : mem[idx][15:8],
                            wrLo ? wrData[7:0]  : mem[idx][7:0]}) ^ corruptWrite;
    end
  end

  // Open-collector: a driven line is always pulled low
  assign dataOut_n        = '0;
  assign slaveSyncOut_n   = 1'b0;
  assign parityFlagAOut_n = 1'b0;
  assign parityErrorOut_n = 1'b0;
  assign dataOe           = dataOe_r;
  assign slaveSyncOe      = slave_sync_r;
  assign parityFlagAOe    = pa_r;
  assign parityErrorOe    = perr_r;
  assign busOccupied      = busy_r;
  assign vectorWord       = vecWord_r;
  assign vectorValid      = vecValid_r;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_readStart;
    state_r == ST_IDLE && !vecS && msynS && hitWin(addrS) && !isWrite;
  endsequence

  a_slave_sync_has_cause: assert property ($rose(slave_sync_r) |-> $past(msynS) || $past(vecS))
    else $error("slave-sync rose without a strobe");
  a_read_data_first: assert property (s_readStart |=> !slave_sync_r ##1 slave_sync_r)
    else $error("read slave-sync not one cycle after data");
  a_read_lanes: assert property (s_readStart |=> dataOe_r == $past(mem[idx]))
    else $error("read data lanes wrong");
  a_miss_silent: assert property (state_r == ST_IDLE && msynS && !vecS && !hitWin(addrS)
                                  |=> !slave_sync_r)
    else $error("answered outside window");
  a_vector_take: assert property (state_r == ST_IDLE && vecS |=> vectorValid && slave_sync_r
                                  && vectorWord == $past(dataS))
    else $error("vector not taken");
  a_vector_no_read: assert property (state_r == ST_IDLE && vecS |=> dataOe_r == $past(dataOe_r))
    else $error("vector cycle drove data");
  a_byte_lane: assert property (state_r == ST_IDLE && !vecS && msynS && hitWin(addrS)
                                && isByte |-> wrHi == addrS[0] && wrLo == !addrS[0])
    else $error("byte lane select wrong");
  a_release_slave_sync: assert property (state_r == ST_HOLD && !msynS && !vecS
                                   |=> !slave_sync_r && dataOe_r == '0 && !perr_r)
    else $error("lines not released after strobe");
  a_parity_off: assert property ((s_readStart and parityCheckOff) |=> pa_r && !perr_r)
    else $error("parity disable not shown");
  a_busy_follow: assert property (busyS |=> busOccupied)
    else $error("busy not reported");
endmodule
`default_nettype wire

// ===== hdl/abt_pkg.sv
// Shared constants for the asynchronous backplane slave with vector intake.
// Assumes bus pins arrive as active-low open-collector levels.
`default_nettype none
package abt_pkg;
  // Bus widths
  localparam int ADDR_W   = 18;
  localparam int DATA_W   = 16;
  // Cycle-control codes (logical levels, high line first)
  localparam logic [1:0] CYC_READ_WORD   = 2'h0;
  localparam logic [1:0] CYC_READ_MODIFY = 2'h1;
  localparam logic [1:0] CYC_WRITE_WORD  = 2'h2;
  localparam logic [1:0] CYC_WRITE_BYTE  = 2'h3;
  // Local memory window: 64 words at a fixed base
  localparam int MEM_WORDS = 64;
  localparam int IDX_W     = 6;
  localparam int IDX_LSB   = 1;
  localparam int WIN_LSB   = IDX_LSB + IDX_W;
  localparam logic [ADDR_W-1:0] BASE_ADDR = 18'h3F000;
  // Pin synchroniser depth
  localparam int SYNC_STAGES = 3;
  // Slave state codes, Gray along the usual path
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_LOAD = 3'h1,
    ST_ACK  = 3'h3,
    ST_HOLD = 3'h2
  } abt_state_e;
endpackage
`default_nettype wire

// ===== hdl/abt_pin_sync.sv
// Three-stage pin synchroniser; a change is taken once stages two and three agree.
// Assumes inputs are asynchronous to sys_clk.
`default_nettype none
module abt_pin_sync
  import abt_pkg::*;
#(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] pinIn,
  input  wire logic [W-1:0] initVal,
  // Filtered level
  output logic      [W-1:0] pinOut
);
  logic [W-1:0] s1_r, s2_r, s3_r, out_r;
  logic [W-1:0] out_nxt;

  // Only bits where the last two stages agree may move
  always_comb begin
    out_nxt = (s2_r & ~(s2_r ^ s3_r)) | (out_r & (s2_r ^ s3_r));
  end

  // Stage one feeds stage two only; reset to all ones (released lines)
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r  <= '1;
      s2_r  <= '1;
      s3_r  <= '1;
      out_r <= '1;
    end else begin
      s1_r  <= pinIn;
      s2_r  <= s1_r;
      s3_r  <= s2_r;
      out_r <= out_nxt;
    end
  end

  // Released level maps onto initVal; all-ones initVal passes the pin level as is
  assign pinOut = out_r ^ ~initVal;
endmodule
`default_nettype wire

// ===== bench/abt_bus_master.sv
// Bus master model for the backplane slave: word, byte and vector cycles on the pins.
// Assumes 100 MHz sys_clk; released lines float high through the terminator pull-ups.
`default_nettype none
module abt_bus_master
  import abt_pkg::*;
(
  // Clock
  input  wire logic              sys_clk,
  // Pins toward the slave
  output var logic               busOccupiedIn_n,
  output var logic [ADDR_W-1:0]  addrIn_n,
  output var logic [1:0]         cycleCtlIn_n,
  output wire logic [DATA_W-1:0] dataIn_n,
  output var logic               masterSyncIn_n,
  output var logic               vectorStrobeIn_n,
  // Slave drives
  input  wire logic [DATA_W-1:0] dataOe,
  input  wire logic              slaveSyncOe,
  input  wire logic              parityFlagAOe,
  input  wire logic              parityErrorOe,
  input  wire logic              busOccupied,
  // Result of the last cycle
  output var logic               done,
  output var logic               ack,
  output var logic               bsy,
  output var logic               steady,
  output var logic [DATA_W-1:0]  q,
  output var logic [1:0]         par
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [DATA_W-1:0] drv;
  logic [DATA_W-1:0] first;

  // Wired data lines: any enabled driver pulls low, otherwise the pull-up wins
  assign dataIn_n = ~(drv | dataOe);

  // Everything released at time zero
  initial begin
    {busOccupiedIn_n, masterSyncIn_n, vectorStrobeIn_n, done} = 4'hE;
    addrIn_n     = '1;
    cycleCtlIn_n = '1;
    drv          = '0;
  end

  // One whole cycle; slack stretches the deskew to act slow as well as prompt
  task automatic xfer(input logic [1:0] kind, input logic vec, input logic [ADDR_W-1:0] a,
                      input logic [DATA_W-1:0] d, input int unsigned slack);
    int n;
    @(negedge sys_clk);
    busOccupiedIn_n = 1'b0;
    addrIn_n        = ~a;
    cycleCtlIn_n    = ~kind;
    drv             = (vec || kind[1]) ? d : '0;
    if (vec) begin
      vectorStrobeIn_n = 1'b0;
    end else begin
      repeat (15 + slack) @(negedge sys_clk);
      masterSyncIn_n = 1'b0;
    end
    ack = 1'b0;
    for (n = 0; n < 40 && !ack; n++) begin
      @(negedge sys_clk);
      ack = slaveSyncOe;
    end
    first = ~dataIn_n;
    bsy   = busOccupied;
    repeat (8) @(negedge sys_clk);
    q      = ~dataIn_n;
    par    = {parityFlagAOe, parityErrorOe};
    steady = (q === first);
    {masterSyncIn_n, vectorStrobeIn_n} = 2'h3;
    drv = '0;
    // Tail deskew before the address goes
    repeat (8) @(negedge sys_clk);
    busOccupiedIn_n = 1'b1;
    addrIn_n        = '1;
    cycleCtlIn_n    = '1;
    for (n = 0; n < 40 && slaveSyncOe; n++) @(negedge sys_clk);
    done = 1'b1;
    @(negedge sys_clk);
    done = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== bench/async_bus_data_transfer_tb.sv
// Self-checking bench for the backplane slave: words, byte lanes, parity and vectors.
// Assumes abt_bus_master on the pins; results are judged against a queue of notes.
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module async_bus_data_transfer_tb
  import abt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic ack; logic rd; logic [15:0] q; logic [1:0] par;} abt_note_s;
  localparam abt_note_s WR = '{1'b1, 1'b0, 16'h0, 2'h0};
  localparam abt_note_s NOACK = '{1'b0, 1'b0, 16'h0, 2'h0};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic parityCheckOff = 1'b0;
  logic corruptWrite = 1'b0;
  logic busOccIn_n, mSync_n, vStrobe_n, sSyncOe, parAOe, parErrOe, busOccupied;
  logic vectorValid, done, ack, bsy, steady;
  logic [1:0] cycCtl_n, par;
  logic [ADDR_W-1:0] addr_n, a;
  logic [DATA_W-1:0] dataIn_n, dataOe, vectorWord, q, w0, w1, w2;
  abt_note_s notes[$];
  abt_note_s e;
  logic [DATA_W-1:0] vecs[$];
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;

  // Free-running clock
  always #5 sys_clk = ~sys_clk;

  abt_slave i_dut (.sys_clk(sys_clk), .rst_n(rst_n), .busOccupiedIn_n(busOccIn_n),
    .addrIn_n(addr_n), .cycleCtlIn_n(cycCtl_n), .dataIn_n(dataIn_n),
    .masterSyncIn_n(mSync_n), .vectorStrobeIn_n(vStrobe_n), .dataOut_n(), .dataOe(dataOe),
    .slaveSyncOut_n(), .slaveSyncOe(sSyncOe), .parityFlagAOut_n(), .parityFlagAOe(parAOe),
    .parityErrorOut_n(), .parityErrorOe(parErrOe), .parityCheckOff(parityCheckOff),
    .corruptWrite(corruptWrite), .busOccupied(busOccupied), .vectorWord(vectorWord),
    .vectorValid(vectorValid));

  abt_bus_master i_master (.sys_clk(sys_clk), .busOccupiedIn_n(busOccIn_n),
    .addrIn_n(addr_n), .cycleCtlIn_n(cycCtl_n), .dataIn_n(dataIn_n),
    .masterSyncIn_n(mSync_n), .vectorStrobeIn_n(vStrobe_n), .dataOe(dataOe),
    .slaveSyncOe(sSyncOe), .parityFlagAOe(parAOe), .parityErrorOe(parErrOe),
    .busOccupied(busOccupied), .done(done), .ack(ack), .bsy(bsy), .steady(steady), .q(q),
    .par(par));

  task automatic report_and_stop();
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Note the expectation first, then run the cycle
  task automatic op(input logic [1:0] k, input logic v, input logic [ADDR_W-1:0] ad,
                    input logic [DATA_W-1:0] d, input abt_note_s x);
    notes.push_back(x);
    i_master.xfer(k, v, ad, d, $urandom_range(0, 6));
  endtask

  // Main sequence, inputs move on falling edges only
  initial begin
    void'($urandom(32'h2981F3B4));
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk) rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    {w0, w1, w2} = {16'($urandom), 16'($urandom), 16'($urandom)};
    op(CYC_WRITE_WORD, 1'b0, BASE_ADDR + 18'h3, w0, WR);
    op(CYC_READ_WORD, 1'b0, BASE_ADDR + 18'h2, 16'h0, '{1'b1, 1'b1, w0, 2'h0});
    // Top word of the window, then each byte lane; the other lane carries junk
    op(CYC_WRITE_WORD, 1'b0, BASE_ADDR + 18'h7E, w1, WR);
    op(CYC_WRITE_BYTE, 1'b0, BASE_ADDR + 18'h7E, w2, WR);
    op(CYC_WRITE_BYTE, 1'b0, BASE_ADDR + 18'h7F, ~w2, WR);
    op(CYC_READ_MODIFY, 1'b0, BASE_ADDR + 18'h7E, 16'h0,
       '{1'b1, 1'b1, {~w2[15:8], w2[7:0]}, 2'h0});
    // Stored bad parity, reported and then masked
    corruptWrite = 1'b1;
    op(CYC_WRITE_WORD, 1'b0, BASE_ADDR + 18'h4, w1, WR);
    corruptWrite = 1'b0;
    op(CYC_READ_WORD, 1'b0, BASE_ADDR + 18'h4, 16'h0, '{1'b1, 1'b1, w1, 2'h1});
    parityCheckOff = 1'b1;
    op(CYC_READ_WORD, 1'b0, BASE_ADDR + 18'h5, 16'h0, '{1'b1, 1'b1, w1, 2'h2});
    parityCheckOff = 1'b0;
    // Just past the window and one far bit off: nobody answers
    op(CYC_READ_WORD, 1'b0, BASE_ADDR + 18'h80, 16'h0, NOACK);
    op(CYC_WRITE_WORD, 1'b0, BASE_ADDR ^ 18'h20000, w0, NOACK);
    // Vector with junk address and control
    vecs.push_back(w2);
    op(2'($urandom), 1'b1, 18'($urandom), w2, WR);
    // Random words across the window, read back with a random bit zero
    for (int i = 0; i < 6; i++) begin
      a  = BASE_ADDR + 18'({6'($urandom), 1'b0});
      w0 = 16'($urandom);
      op(CYC_WRITE_WORD, 1'b0, a, w0, WR);
      op(CYC_READ_WORD, 1'b0, a | 18'($urandom_range(0, 1)), 16'h0, '{1'b1, 1'b1, w0, 2'h0});
    end
    repeat (5) @(negedge sys_clk);
    report_and_stop();
  end

  // Result watcher: oldest note against each finished cycle, oldest queued vector word against each vector
  always @(posedge sys_clk) begin
    if (done && notes.size() == 0) n_mismatch++;
    if (done && notes.size() > 0) begin
      e = notes.pop_front();
      `CHK("ack", e.ack, ack)
      `CHK("busy", 1'b1, bsy)
      if (e.rd) begin
        `CHK("data", e.q, q)
        `CHK("parity", e.par, par)
        `CHK("steady", 1'b1, steady)
      end
    end
    if (vectorValid === 1'b1 && vecs.size() == 0) n_mismatch++;
    if (vectorValid === 1'b1 && vecs.size() > 0) begin
      `CHK("vector", vecs.pop_front(), vectorWord)
    end
  end

  // Hang guard, far above the expected run of about 1050 cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 8000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
endmodule
`default_nettype wire
